// ---- rtl/rst_pkg.sv ----
// Constants, register map and carrier types of the reset sequencer
// Function
// RULE_01 - Run mode sources start a system reset
// RULE_02 - Stop mode wake sources start recovery
// RULE_03 - Both kinds hold 66 slow, 16 fast
// RULE_04 - System reset loads control register defaults
// RULE_05 - Recovery touches only watchdog control register
// RULE_06 - System reset forces all port pins input
// RULE_07 - Clock starts after slow count, CPU idle
// RULE_08 - CPU fetches vector at 0002h, 0003h
// RULE_09 - Supply faults override every other source
// RULE_10 - Supply good: 66 slow, then 16 fast
// RULE_11 - Supply reset completion sets power flag
// RULE_12 - Brown-out holds reset, then full sequence
// RULE_13 - Option keeps brown-out alive in stop
// RULE_14 - Watchdog resets when select option is 1
// RULE_15 - Watchdog caused reset sets watchdog flag
// RULE_16 - Reset pin must stay low 4 clocks
// RULE_17 - Held pin holds reset, exits on release
// RULE_18 - Pin caused reset sets pin flag
// RULE_19 - Debugger request resets chip except debugger
// RULE_20 - Debugger bit self clears, power flag set
// RULE_21 - Any recovery sets the stop flag
// RULE_22 - Enabled pin wakes on either edge
// RULE_23 - Asynchronous requests synchronised before counters
`default_nettype none
package rst_pkg;
	// Sequence lengths
	localparam int unsigned WDT_OSC_CYCLES = 66;
	localparam int unsigned SETTLE_CYCLES = 16;
	localparam int unsigned EXT_FILTER_CYCLES = 4;
	localparam int unsigned WDT_DIV_DEFAULT = 25000;
	localparam logic [7:0] OSC_LAST = 8'(WDT_OSC_CYCLES - 1);
	localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
	// Reset vector bytes
	localparam logic [15:0] VECTOR_ADDR_HI = 16'h0002;
	localparam logic [15:0] VECTOR_ADDR_LO = 16'h0003;
	// Register byte offsets
	localparam logic [4:0] OFS_WDCTL = 5'h00;
	localparam logic [4:0] OFS_DBGCTL = 5'h04;
	localparam logic [4:0] OFS_CONFIG = 5'h08;
	localparam logic [4:0] OFS_WAKE_EN = 5'h0C;
	localparam logic [4:0] OFS_STATE = 5'h10;
	// Field positions
	localparam int unsigned FLAGS_LSB = 4;
	localparam int unsigned CFG_SEL_BIT = 0;
	localparam int unsigned CFG_BO_BIT = 1;
	// Values after reset
	localparam logic WDT_SEL_RESET = 1'b1;
	localparam logic BO_STOP_RESET = 1'b0;

	typedef struct packed {
		logic por;
		logic stop;
		logic wdt;
		logic external_pin_cause_flag;
	} cause_s;

	typedef struct packed {
		logic brownout_in_stop_option;
		logic watchdog_reset_select_option;
	} config_s;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
	} avs_req_s;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_STOP,
		ST_OSC_COUNT,
		ST_SETTLE,
		ST_PIN_HOLD,
		ST_FETCH_HI,
		ST_FETCH_LO
	} seq_state_e;
endpackage
`default_nettype wire

// ---- rtl/sync_filter.sv ----
// Two-stage synchroniser with an optional stability filter
`default_nettype none
module sync_filter
#(
	parameter int unsigned W = 1,
	parameter int unsigned FILT = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	localparam int unsigned CW = (FILT > 1) ? $clog2(FILT) : 1;
	localparam logic [CW-1:0] CNT_LAST = CW'(FILT - 1);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] dout_ff;
	logic [CW-1:0] cnt_ff;

	// Stage one is read only by stage two
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end
		else
		begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end

	// New level accepted only after FILT differing cycles
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dout_ff <= RST_VAL;
			cnt_ff <= '0;
		end
		else if (sync_ff == dout_ff)
			cnt_ff <= '0;
		else if (cnt_ff == CNT_LAST)
		begin
			dout_ff <= sync_ff;
			cnt_ff <= '0;
		end
		else
			cnt_ff <= cnt_ff + CW'(1);
	end

	assign dout = dout_ff;
endmodule
`default_nettype wire

// ---- rtl/reset_and_stop_recovery_ctrl.sv ----
// Reset and stop-mode recovery sequencer with Avalon-MM registers
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`default_nettype none
module reset_and_stop_recovery_ctrl
	import rst_pkg::*;
#(
	parameter int unsigned WDT_DIV = WDT_DIV_DEFAULT,
	parameter int unsigned NPINS = 8
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire avs_req_s avs_req,
	output logic avs_waitrequest,
	output logic [31:0] avs_readdata,
	input wire logic supply_ok,
	input wire logic brownout_detector,
	input wire logic watchdog_timeout,
	input wire logic ext_reset_n,
	input wire logic debug_pin,
	input wire logic [NPINS-1:0] port_pins,
	input wire logic stop_entry,
	output logic cpu_reset_n,
	output logic periph_reset_n,
	output logic sysclk_enable,
	output logic gpio_force_input,
	output logic ctrl_reg_load,
	output logic vector_fetch,
	output logic [15:0] vector_addr,
	output logic stop_active
);
	localparam int unsigned DW = (WDT_DIV > 1) ? $clog2(WDT_DIV) : 1;
	localparam logic [DW-1:0] DIV_LAST = DW'(WDT_DIV - 1);

	// Synchronised inputs
	logic supply_s;
	logic brownout_s;
	logic wdt_s;
	logic ext_n_s;
	logic debug_s;
	logic [NPINS-1:0] port_s;

	// State
	seq_state_e state_ff;
	seq_state_e nxt_state;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [DW-1:0] div_ff;
	logic wdt_tick_ff;
	logic sysrst_ff;
	logic nxt_sysrst;
	cause_s pend_ff;
	cause_s nxt_pend;
	cause_s flags_ff;
	config_s cfg_ff;
	logic dbg_req_ff;
	logic [NPINS-1:0] wake_en_ff;
	logic wdt_prev_ff;
	logic [NPINS-1:0] port_prev_ff;
	logic done;

	// Register outputs
	logic waitreq_ff;
	logic [31:0] rdata_ff;
	logic cpu_rst_n_ff;
	logic per_rst_n_ff;
	logic sysclk_ff;
	logic gpio_in_ff;
	logic reg_load_ff;
	logic fetch_ff;
	logic [15:0] vaddr_ff;
	logic stop_ff;

	// Requests and events
	logic in_stop;
	logic in_reset;
	logic por_req;
	logic ext_low;
	logic wdt_ev;
	logic wake_ev;
	logic run_req;
	logic stop_sys_req;
	logic stop_wake_req;
	logic bus_write;
	logic [31:0] rd_mux;

	// Pins and foreign signals cross in before any logic reads them
	sync_filter #(.W(1), .FILT(1), .RST_VAL(1'b0)) u_sync_supply ( // RULE_23
		.clk(clk),
		.resetn(resetn),
		.din(supply_ok),
		.dout(supply_s)
	);
	sync_filter #(.W(1), .FILT(1), .RST_VAL(1'b0)) u_sync_bo (
		.clk(clk),
		.resetn(resetn),
		.din(brownout_detector),
		.dout(brownout_s)
	);
	sync_filter #(.W(1), .FILT(1), .RST_VAL(1'b0)) u_sync_wdt (
		.clk(clk),
		.resetn(resetn),
		.din(watchdog_timeout),
		.dout(wdt_s)
	);
	// Noise filter: a low shorter than the filter length is ignored
	sync_filter #(.W(1), .FILT(EXT_FILTER_CYCLES), .RST_VAL(1'b1))
		u_sync_ext ( // RULE_16
		.clk(clk),
		.resetn(resetn),
		.din(ext_reset_n),
		.dout(ext_n_s)
	);
	sync_filter #(.W(1), .FILT(1), .RST_VAL(1'b1)) u_sync_dbg (
		.clk(clk),
		.resetn(resetn),
		.din(debug_pin),
		.dout(debug_s)
	);
	sync_filter #(.W(NPINS), .FILT(1), .RST_VAL('0)) u_sync_port (
		.clk(clk),
		.resetn(resetn),
		.din(port_pins),
		.dout(port_s)
	);

	// Watchdog oscillator rate as a one-cycle enable
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_ff <= '0;
			wdt_tick_ff <= 1'b0;
		end
		else if (div_ff == DIV_LAST)
		begin
			div_ff <= '0;
			wdt_tick_ff <= 1'b1;
		end
		else
		begin
			div_ff <= div_ff + DW'(1);
			wdt_tick_ff <= 1'b0;
		end
	end

	// Edge history for watchdog and wake pins
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wdt_prev_ff <= 1'b0;
			port_prev_ff <= '0;
		end
		else
		begin
			wdt_prev_ff <= wdt_s;
			port_prev_ff <= port_s;
		end
	end

	// Request decode; supply faults are handled ahead of all others
	always_comb
	begin
		in_stop = (state_ff == ST_STOP);
		in_reset = (state_ff == ST_OSC_COUNT) || (state_ff == ST_SETTLE) ||
			(state_ff == ST_PIN_HOLD);
		por_req = !supply_s || (brownout_s && // RULE_12
			(!in_stop || cfg_ff.brownout_in_stop_option)); // RULE_13
		ext_low = !ext_n_s;
		wdt_ev = wdt_s && !wdt_prev_ff;
		wake_ev = |((port_s ^ port_prev_ff) & wake_en_ff); // RULE_22
		run_req = por_req || ext_low || dbg_req_ff || // RULE_01
			(wdt_ev && cfg_ff.watchdog_reset_select_option); // RULE_14
		stop_sys_req = por_req || ext_low;
		stop_wake_req = wdt_ev || wake_ev || !debug_s; // RULE_02
	end

	// Sequencer next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sysrst = sysrst_ff;
		nxt_pend = pend_ff;
		done = 1'b0;
		case (state_ff)
			ST_RUN:
			begin
				if (run_req)
				begin
					nxt_state = ST_OSC_COUNT;
					nxt_cnt = '0;
					nxt_sysrst = 1'b1;
					nxt_pend = '0;
					nxt_pend.por = por_req || dbg_req_ff; // RULE_20
					nxt_pend.wdt = !por_req && wdt_ev; // RULE_09 RULE_15
					nxt_pend.external_pin_cause_flag = !por_req && ext_low; // RULE_18
				end
				else if (stop_entry)
					nxt_state = ST_STOP;
			end
			ST_STOP:
			begin
				if (stop_sys_req)
				begin
					nxt_state = ST_OSC_COUNT;
					nxt_cnt = '0;
					nxt_sysrst = 1'b1;
					nxt_pend = '0;
					nxt_pend.por = por_req;
					nxt_pend.external_pin_cause_flag = !por_req && ext_low;
				end
				else if (stop_wake_req)
				begin
					nxt_state = ST_OSC_COUNT;
					nxt_cnt = '0;
					nxt_sysrst = 1'b0;
					nxt_pend = '0;
					nxt_pend.stop = 1'b1;
					nxt_pend.wdt = wdt_ev;
				end
			end
			ST_OSC_COUNT:
			begin
				if (wdt_tick_ff)
				begin
					if (cnt_ff == OSC_LAST) // RULE_10
					begin
						nxt_state = ST_SETTLE;
						nxt_cnt = '0;
					end
					else
						nxt_cnt = cnt_ff + 8'h01;
				end
			end
			ST_SETTLE:
			begin
				if (cnt_ff == SETTLE_LAST) // RULE_03
				begin
					nxt_state = ext_low ? ST_PIN_HOLD : ST_FETCH_HI;
					done = !ext_low;
				end
				else
					nxt_cnt = cnt_ff + 8'h01;
			end
			ST_PIN_HOLD:
			begin
				// Held pin: leave at once on release
				if (!ext_low) // RULE_17
				begin
					nxt_state = ST_FETCH_HI;
					done = 1'b1;
				end
			end
			ST_FETCH_HI:
				nxt_state = ST_FETCH_LO;
			ST_FETCH_LO:
				nxt_state = ST_RUN;
			default:
				nxt_state = ST_RUN;
		endcase
		// A supply fault restarts the whole sequence as a full reset
		if (por_req && in_reset) // RULE_09
		begin
			nxt_state = ST_OSC_COUNT;
			nxt_cnt = '0;
			nxt_sysrst = 1'b1;
			nxt_pend = '0;
			nxt_pend.por = 1'b1;
			done = 1'b0;
		end
	end

	// Sequencer registers; power-up runs the full sequence
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= ST_OSC_COUNT;
			cnt_ff <= '0;
			sysrst_ff <= 1'b1;
			pend_ff <= '{por: 1'b1, stop: 1'b0, wdt: 1'b0, external_pin_cause_flag: 1'b0};
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sysrst_ff <= nxt_sysrst;
			pend_ff <= nxt_pend;
		end
	end

	// Outputs follow the next state so they change with it
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cpu_rst_n_ff <= 1'b0;
			per_rst_n_ff <= 1'b0;
			sysclk_ff <= 1'b0;
			gpio_in_ff <= 1'b1;
			reg_load_ff <= 1'b1;
			stop_ff <= 1'b0;
		end
		else
		begin
			cpu_rst_n_ff <= !(nxt_state inside {ST_OSC_COUNT, ST_SETTLE,
				ST_PIN_HOLD}); // RULE_03
			per_rst_n_ff <= !(nxt_sysrst && (nxt_state inside // RULE_07
				{ST_OSC_COUNT, ST_SETTLE, ST_PIN_HOLD}));
			sysclk_ff <= !(nxt_state inside {ST_OSC_COUNT, ST_STOP}); // RULE_07
			gpio_in_ff <= nxt_sysrst && (nxt_state inside // RULE_06
				{ST_OSC_COUNT, ST_SETTLE, ST_PIN_HOLD});
			// Recovery leaves peripheral registers untouched
			reg_load_ff <= nxt_sysrst && (nxt_state inside // RULE_04
				{ST_OSC_COUNT, ST_SETTLE, ST_PIN_HOLD}); // RULE_05
			stop_ff <= (nxt_state == ST_STOP);
		end
	end

	// Vector fetch: high byte address, then low byte address
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fetch_ff <= 1'b0;
			vaddr_ff <= '0;
		end
		else if (nxt_state == ST_FETCH_HI) // RULE_08
		begin
			fetch_ff <= 1'b1;
			vaddr_ff <= VECTOR_ADDR_HI;
		end
		else if (nxt_state == ST_FETCH_LO)
		begin
			fetch_ff <= 1'b1;
			vaddr_ff <= VECTOR_ADDR_LO;
		end
		else
		begin
			fetch_ff <= 1'b0;
			vaddr_ff <= '0;
		end
	end

	// Bus write takes effect at the edge where waitrequest is low
	assign bus_write = avs_req.write && !waitreq_ff;

	// Cause flags: write one to clear, completion wins over a clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			flags_ff <= '0;
		else if (done && sysrst_ff)
			flags_ff <= pend_ff; // RULE_11
		else if (done)
			flags_ff <= flags_ff | pend_ff; // RULE_21
		else if (bus_write && avs_req.address == OFS_WDCTL)
			flags_ff <= flags_ff & ~cause_s'(avs_req.writedata[FLAGS_LSB +: 4]);
	end

	// Debugger request clears itself once its reset is running
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			dbg_req_ff <= 1'b0;
		else if (in_reset && sysrst_ff)
			dbg_req_ff <= 1'b0; // RULE_20
		else if (bus_write && avs_req.address == OFS_DBGCTL)
			dbg_req_ff <= avs_req.writedata[0]; // RULE_19
	end

	// Configuration and wake enables survive system reset
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_ff.watchdog_reset_select_option <= WDT_SEL_RESET;
			cfg_ff.brownout_in_stop_option <= BO_STOP_RESET;
			wake_en_ff <= '0;
		end
		else if (bus_write && avs_req.address == OFS_CONFIG)
		begin
			cfg_ff.watchdog_reset_select_option <=
				avs_req.writedata[CFG_SEL_BIT];
			cfg_ff.brownout_in_stop_option <= avs_req.writedata[CFG_BO_BIT];
		end
		else if (bus_write && avs_req.address == OFS_WAKE_EN)
			wake_en_ff <= avs_req.writedata[NPINS-1:0];
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		rd_mux = '0;
		case (avs_req.address)
			OFS_WDCTL: rd_mux[FLAGS_LSB +: 4] = flags_ff;
			OFS_DBGCTL: rd_mux[0] = dbg_req_ff;
			OFS_CONFIG:
			begin
				rd_mux[CFG_SEL_BIT] = cfg_ff.watchdog_reset_select_option;
				rd_mux[CFG_BO_BIT] = cfg_ff.brownout_in_stop_option;
			end
			OFS_WAKE_EN: rd_mux[NPINS-1:0] = wake_en_ff;
			OFS_STATE:
			begin
				rd_mux[2:0] = state_ff;
				rd_mux[3] = sysrst_ff;
				rd_mux[8:4] = {supply_s, brownout_s, ext_n_s, debug_s, wdt_s};
			end
			default: rd_mux = '0;
		endcase
	end

	// One wait state per access, then release for one cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			waitreq_ff <= 1'b1;
			rdata_ff <= '0;
		end
		else if (!waitreq_ff)
			waitreq_ff <= 1'b1;
		else if (avs_req.read || avs_req.write)
		begin
			waitreq_ff <= 1'b0;
			rdata_ff <= rd_mux;
		end
	end

	assign avs_waitrequest = waitreq_ff;
	assign avs_readdata = rdata_ff;
	assign cpu_reset_n = cpu_rst_n_ff;
	assign periph_reset_n = per_rst_n_ff;
	assign sysclk_enable = sysclk_ff;
	assign gpio_force_input = gpio_in_ff;
	assign ctrl_reg_load = reg_load_ff;
	assign vector_fetch = fetch_ff;
	assign vector_addr = vaddr_ff;
	assign stop_active = stop_ff;
endmodule
`default_nettype wire

// ---- tb/rst_seq_asserts.sv ----
// Concurrent checks on the reset sequencer ports
`default_nettype none
module rst_seq_asserts
	import rst_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire avs_req_s avs_req,
	input wire logic avs_waitrequest,
	input wire logic supply_ok,
	input wire logic ext_reset_n,
	input wire logic debug_pin,
	input wire logic cpu_reset_n,
	input wire logic periph_reset_n,
	input wire logic sysclk_enable,
	input wire logic gpio_force_input,
	input wire logic ctrl_reg_load,
	input wire logic vector_fetch,
	input wire logic [15:0] vector_addr,
	input wire logic stop_active
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// High vector byte first, then low, then idle
	sequence s_fetch;
		vector_fetch && vector_addr == VECTOR_ADDR_HI ##1
		vector_fetch && vector_addr == VECTOR_ADDR_LO ##1 !vector_fetch;
	endsequence
	// Sixteen fast clocks with the CPU still held
	sequence s_settle;
		!cpu_reset_n [*8] ##1 !cpu_reset_n [*8];
	endsequence
	a_vector_order: assert property
		($rose(cpu_reset_n) |-> s_fetch)
		else $error("vector fetch out of order");
	a_vector_idle: assert property
		(!vector_fetch |-> vector_addr == 16'h0000)
		else $error("vector address outside fetch");
	a_settle_hold: assert property
		($rose(sysclk_enable) && !cpu_reset_n |-> s_settle)
		else $error("released before settle count");
	a_clock_first: assert property
		($rose(cpu_reset_n) |-> $past(sysclk_enable, 16))
		else $error("clock not running before release");
	a_bus_answer: assert property
		((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");
	a_port_input: assert property
		(gpio_force_input == !periph_reset_n)
		else $error("port pins not forced in system reset");
	a_defaults_load: assert property
		(ctrl_reg_load == gpio_force_input)
		else $error("register reload not tied to system reset");
	a_pin_holds: assert property
		(!ext_reset_n [*8] |-> ##[0:3] !cpu_reset_n)
		else $error("held reset pin ignored");
	a_supply_fault: assert property
		(!supply_ok [*8] |-> !periph_reset_n)
		else $error("low supply without system reset");
	a_debug_wake: assert property
		(stop_active && !debug_pin |-> ##[0:6] !cpu_reset_n)
		else $error("debug pin did not wake");
endmodule

bind reset_and_stop_recovery_ctrl rst_seq_asserts i_rst_seq_asserts (
	.clk(clk), .resetn(resetn), .avs_req(avs_req),
	.avs_waitrequest(avs_waitrequest), .supply_ok(supply_ok),
	.ext_reset_n(ext_reset_n), .debug_pin(debug_pin),
	.cpu_reset_n(cpu_reset_n), .periph_reset_n(periph_reset_n),
	.sysclk_enable(sysclk_enable), .gpio_force_input(gpio_force_input),
	.ctrl_reg_load(ctrl_reg_load), .vector_fetch(vector_fetch),
	.vector_addr(vector_addr), .stop_active(stop_active));
`default_nettype wire

// ---- tb/far_side_model.sv ----
// Far-side model: supply monitors, reset pin, watchdog and pins
`default_nettype none
module far_side_model
(
	input wire logic clk,
	input wire logic power_good,
	input wire logic brownout_req,
	input wire logic dog_kick,
	input wire logic pin_req,
	input wire logic [3:0] pin_min,
	input wire logic debug_low,
	input wire logic [7:0] wake_lvl,
	output logic supply_ok,
	output logic brownout_detector,
	output logic watchdog_timeout,
	output logic ext_reset_n,
	output logic debug_pin,
	output logic [7:0] port_pins
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] dog_cnt = 4'h0;
	logic [3:0] pin_cnt = 4'h0;
	// Time-out stretched so the far synchroniser cannot miss it
	always_ff @(posedge clk)
		dog_cnt <= dog_kick ? 4'h4 : dog_cnt - 4'(dog_cnt != 4'h0);
	// Pin kept low pin_min clocks; below four only on a glitch run
	always_ff @(posedge clk)
		pin_cnt <= pin_req ? pin_min : pin_cnt - 4'(pin_cnt != 4'h0);
	// Levels follow the bench requests right after each edge
	assign watchdog_timeout = dog_cnt != 4'h0;
	assign ext_reset_n = !(pin_req || pin_cnt > 4'h1);
	assign supply_ok = power_good;
	assign brownout_detector = brownout_req;
	assign debug_pin = !debug_low;
	assign port_pins = wake_lvl;
endmodule
`default_nettype wire

// ---- tb/reset_and_stop_recovery_ctrl_tb.sv ----
// Self-checking bench for the reset and stop recovery sequencer
`default_nettype none
module reset_and_stop_recovery_ctrl_tb
	import rst_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned DIV = 3;
	logic clk;
	logic resetn = 1'b0;
	avs_req_s avs_req = '0;
	logic stop_entry = 1'b0;
	logic power_good = 1'b1;
	logic bo_req = 1'b0;
	logic dog_kick = 1'b0;
	logic pin_req = 1'b0;
	logic [3:0] pin_min = 4'h4;
	logic debug_low = 1'b0;
	logic [7:0] wake_lvl = 8'h00;
	logic supply_ok, brownout_detector, watchdog_timeout, ext_reset_n;
	logic debug_pin, avs_waitrequest, cpu_reset_n, periph_reset_n;
	logic sysclk_enable, gpio_force_input, ctrl_reg_load, vector_fetch;
	logic stop_active;
	logic [7:0] port_pins;
	logic [31:0] avs_readdata;
	logic [15:0] vector_addr;
	int fail_count = 0;
	int compares = 0;
	far_side_model i_far_side_model (.clk(clk), .power_good(power_good),
		.brownout_req(bo_req), .dog_kick(dog_kick), .pin_req(pin_req),
		.pin_min(pin_min), .debug_low(debug_low), .wake_lvl(wake_lvl),
		.supply_ok(supply_ok), .brownout_detector(brownout_detector),
		.watchdog_timeout(watchdog_timeout), .ext_reset_n(ext_reset_n),
		.debug_pin(debug_pin), .port_pins(port_pins));
	reset_and_stop_recovery_ctrl #(.WDT_DIV(DIV), .NPINS(8))
		i_reset_and_stop_recovery_ctrl (.clk(clk), .resetn(resetn),
		.avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .supply_ok(supply_ok),
		.brownout_detector(brownout_detector),
		.watchdog_timeout(watchdog_timeout), .ext_reset_n(ext_reset_n),
		.debug_pin(debug_pin), .port_pins(port_pins),
		.stop_entry(stop_entry), .cpu_reset_n(cpu_reset_n),
		.periph_reset_n(periph_reset_n), .sysclk_enable(sysclk_enable),
		.gpio_force_input(gpio_force_input), .ctrl_reg_load(ctrl_reg_load),
		.vector_fetch(vector_fetch), .vector_addr(vector_addr),
		.stop_active(stop_active));
	// Clock of 4 ns
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Status word expected for a set of cause bits
	function automatic logic [31:0] flags(logic [3:0] c);
		return 32'(c) << FLAGS_LSB;
	endfunction
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(logic wr, logic [4:0] a, logic [31:0] d,
		output logic [31:0] q);
		avs_req <= {!wr, wr, a, d};
		do
		begin
			@(posedge clk);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_req <= '0;
		@(posedge clk);
	endtask
	task automatic wr(logic [4:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(string nm, logic [4:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(nm, q, e);
	endtask
	task automatic kick();
		dog_kick <= 1'b1;
		cyc(1);
		dog_kick <= 1'b0;
	endtask
	task automatic stop_go();
		stop_entry <= 1'b1;
		cyc(1);
		stop_entry <= 1'b0;
		cyc(4);
		chk("stop", stop_active, 1);
	endtask
	// Waits out one sequence; md 0 exit only, 1 settle, 2 settle and slow
	task automatic run_seq(string nm, int md, logic per, logic [3:0] fl);
		int sl, fa, n;
		logic p;
		n = 0;
		while (cpu_reset_n !== 1'b0 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		p = periph_reset_n;
		sl = 0;
		fa = 0;
		while (sysclk_enable !== 1'b1 && sl < 3000)
		begin
			@(posedge clk);
			sl++;
		end
		while (cpu_reset_n !== 1'b1 && fa < 3000)
		begin
			@(posedge clk);
			fa++;
		end
		cyc(4);
		chk({nm, " kind"}, p, per);
		// Release waits for pin tail, two sync stages and the filter
		if (md == 0)
			chk({nm, " exit"}, fa <= EXT_FILTER_CYCLES + 8, 1);
		else
			chk({nm, " settle"}, fa, SETTLE_CYCLES);
		if (md == 2)
			chk({nm, " slow"}, sl >= 65 * DIV && sl <= 66 * DIV + 1, 1);
		rdc({nm, " flags"}, OFS_WDCTL, flags(fl));
		wr(OFS_WDCTL, 32'h0000_00F0);
	endtask
	// Hang guard well beyond the longest expected run
	initial
	begin
		repeat (20000) @(posedge clk);
		chk("timeout", 0, 1);
		tally_and_finish();
	end
	initial
	begin
		logic [7:0] en;
		int b;
		void'($urandom(21));
		cyc(2);
		resetn <= 1'b1;
		run_seq("power", 1, 1'b0, 4'b1000);
		rdc("cleared", OFS_WDCTL, 0);
		rdc("config", OFS_CONFIG, 32'h0000_0001);
		rdc("wake", OFS_WAKE_EN, 0);
		rdc("hole", 5'h14, 0);
		// Run state, system kind, supply high, pins idle
		rdc("state", OFS_STATE, 32'h0000_0168);
		kick();
		run_seq("dog", 2, 1'b0, 4'b0010);
		wr(OFS_CONFIG, 0);
		kick();
		cyc(40);
		chk("select off", cpu_reset_n, 1);
		wr(OFS_CONFIG, 1);
		pin_min <= 4'h2;
		pin_req <= 1'b1;
		cyc(1);
		pin_req <= 1'b0;
		cyc(30);
		chk("glitch", cpu_reset_n, 1);
		pin_min <= 4'h4;
		pin_req <= 1'b1;
		cyc(1);
		pin_req <= 1'b0;
		run_seq("pin4", 2, 1'b0, 4'b0001);
		wr(OFS_DBGCTL, 1);
		run_seq("debugger", 2, 1'b0, 4'b1000);
		rdc("request bit", OFS_DBGCTL, 0);
		pin_req <= 1'b1;
		cyc(600);
		chk("held", cpu_reset_n, 0);
		pin_req <= 1'b0;
		run_seq("held", 0, 1'b0, 4'b0001);
		power_good <= 1'b0;
		pin_req <= 1'b1;
		cyc(300);
		chk("low supply", cpu_reset_n, 0);
		power_good <= 1'b1;
		pin_req <= 1'b0;
		run_seq("supply", 1, 1'b0, 4'b1000);
		// Each wake source, with masked pins and brownout ignored first
		for (int k = 0; k < 3; k++)
		begin
			wake_lvl <= 8'($urandom());
			en = 8'($urandom_range(1, 255));
			b = 0;
			while (!en[b])
				b++;
			wr(OFS_WAKE_EN, {24'h0, en});
			wr(OFS_CONFIG, 1);
			stop_go();
			wake_lvl <= wake_lvl ^ ~en;
			bo_req <= 1'b1;
			cyc(20);
			bo_req <= 1'b0;
			cyc(5);
			chk("asleep", {stop_active, cpu_reset_n}, 3);
			case (k)
				0: kick();
				1: wake_lvl <= wake_lvl ^ (8'h01 << b);
				default: debug_low <= 1'b1;
			endcase
			run_seq("wake", 2, 1'b1, k == 0 ? 4'b0110 : 4'b0100);
			debug_low <= 1'b0;
			rdc("kept", OFS_WAKE_EN, {24'h0, en});
		end
		wr(OFS_CONFIG, 3);
		stop_go();
		bo_req <= 1'b1;
		cyc(30);
		bo_req <= 1'b0;
		run_seq("bo stop", 1, 1'b0, 4'b1000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
